// file: design/prd_ref_div.sv
// Module: reference frequency generator with selection register and divider data latch
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Reference frequency is the 4.5 MHz crystal divided down.
// - Thirteen reference frequencies from 1 kHz to 50 kHz are selectable.
// - Codes 0000-0111: 1.25, 2.5, 5, 10, 6.25, 12.5, 25, 50 kHz.
// - Codes 1000, 1001, 1010 give 3, 9 and 18 kHz.
// - Code 1111 disables the synthesizer instead of selecting a frequency.
// - While disabled by code 1111 both oscillator inputs are pulled low.
// - While disabled by code 1111 both error outputs float.
// - Extension flag reaches the divider only on a write to the data register.
// - Code 1111 stops the synthesizer just like a low chip-enable pin.
// - While disabled the comparator issues neither up nor down request.
module prd_ref_div (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // Register port
    input  wire prd_pkg::prd_bus_req_t bus_req,
    output logic [15:0]                bus_rdata,
    // System reset sources and pins
    input  wire logic                  wdt_sp_rst,
    input  wire logic                  ce_rst,
    input  wire logic                  clock_stop,
    input  wire logic                  ce_pin,
    input  wire logic                  xtal_in,
    // Phase comparator raw requests
    input  wire logic                  up_req_raw,
    input  wire logic                  dw_req_raw,
    // Reference and divider outputs
    output logic                       ref_tick,
    output logic                       synth_disable,
    output logic [15:0]                div_value,
    output logic                       swallow_count_ext,
    output logic                       up_req,
    output logic                       dw_req,
    // Pin controls
    output logic                       local_osc_high_band_pulldown,
    output logic                       local_osc_low_band_pulldown,
    output prd_pkg::prd_pin_t          error_output_one,
    output prd_pkg::prd_pin_t          error_output_zero
);
    function automatic logic [12:0] ref_divisor(input logic [3:0] code);
        case (code)
            4'h0:    ref_divisor = prd_pkg::DIV_1K25;
            4'h1:    ref_divisor = prd_pkg::DIV_2K5;
            4'h2:    ref_divisor = prd_pkg::DIV_5K;
            4'h3:    ref_divisor = prd_pkg::DIV_10K;
            4'h4:    ref_divisor = prd_pkg::DIV_6K25;
            4'h5:    ref_divisor = prd_pkg::DIV_12K5;
            4'h6:    ref_divisor = prd_pkg::DIV_25K;
            4'h7:    ref_divisor = prd_pkg::DIV_50K;
            4'h8:    ref_divisor = prd_pkg::DIV_3K;
            4'h9:    ref_divisor = prd_pkg::DIV_9K;
            4'ha:    ref_divisor = prd_pkg::DIV_18K;
            4'hc:    ref_divisor = prd_pkg::DIV_1K;
            4'hd:    ref_divisor = prd_pkg::DIV_20K;
            default: ref_divisor = prd_pkg::DIV_NONE;
        endcase
    endfunction

    logic [3:0]  ref_sel_reg;
    logic        ext_flag_reg;
    logic [15:0] div_value_reg;
    logic        div_ext_reg;
    logic [2:0]  xtal_sync_reg;
    logic [2:0]  ce_sync_reg;
    logic        xtal_filt_reg;
    logic        xtal_prev_reg;
    logic        ce_filt_reg;
    logic [12:0] cnt_reg;
    logic [12:0] cnt_next;
    logic        ref_tick_reg;
    logic [15:0] rdata_reg;
    logic        pd_reg;
    logic        eo_oe_n_reg;
    logic        eo_out_reg;
    logic [12:0] divisor;
    logic        xtal_tick;
    logic        sel_off;
    logic        disabled;
    logic        sel_wr;
    assign divisor   = ref_divisor(ref_sel_reg);
    assign sel_off   = (ref_sel_reg == prd_pkg::REF_SEL_OFF);
    assign disabled  = sel_off || !ce_filt_reg;
    assign sel_wr    = bus_req.wr && (bus_req.addr == prd_pkg::ADDR_REF_SEL);
    assign xtal_tick = xtal_filt_reg && !xtal_prev_reg;

    //////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a change is taken once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            xtal_sync_reg <= 3'h0;
            ce_sync_reg   <= 3'h0;
            xtal_filt_reg <= 1'b0;
            xtal_prev_reg <= 1'b0;
            ce_filt_reg   <= 1'b0;
        end
        else
        begin
            xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_in};
            ce_sync_reg   <= {ce_sync_reg[1:0], ce_pin};
            if (xtal_sync_reg[1] == xtal_sync_reg[2])
                xtal_filt_reg <= xtal_sync_reg[2];
            if (ce_sync_reg[1] == ce_sync_reg[2])
                ce_filt_reg <= ce_sync_reg[2];
            xtal_prev_reg <= xtal_filt_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Selection register; every reset source and clock stop force the off code
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            ref_sel_reg <= prd_pkg::REF_SEL_RST;
        else if (wdt_sp_rst || ce_rst || clock_stop)
            ref_sel_reg <= prd_pkg::REF_SEL_RST;
        else if (sel_wr)
            ref_sel_reg <= bus_req.wdata[3:0];
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Extension flag and divider data latch
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ext_flag_reg  <= 1'b0;
            div_value_reg <= prd_pkg::PLL_DATA_RST;
            div_ext_reg   <= 1'b0;
        end
        else
        begin
            if (bus_req.wr && bus_req.addr == prd_pkg::ADDR_PLL_CTRL)
                ext_flag_reg <= bus_req.wdata[prd_pkg::CTRL_EXT_BIT];
            // Flag travels with the data write only, so the divider never sees a torn pair
            if (bus_req.wr && bus_req.addr == prd_pkg::ADDR_PLL_DATA)
            begin
                div_value_reg <= bus_req.wdata;
                div_ext_reg   <= ext_flag_reg;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Reference divider, counting filtered crystal edges
    always_comb
    begin
        cnt_next = cnt_reg;
        if (sel_wr || disabled || divisor == prd_pkg::DIV_NONE)
            cnt_next = 13'h0000;
        else if (xtal_tick)
        begin
            if (cnt_reg >= divisor - 13'h0001)
                cnt_next = 13'h0000;
            else
                cnt_next = cnt_reg + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_reg      <= 13'h0000;
            ref_tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg      <= cnt_next;
            // One tick per full divisor of crystal edges
            ref_tick_reg <= !sel_wr && !disabled && divisor != prd_pkg::DIV_NONE
                            && xtal_tick
                            && cnt_reg >= divisor - 13'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Pin controls and charge pump drive
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pd_reg      <= 1'b1;
            eo_oe_n_reg <= 1'b1;
            eo_out_reg  <= 1'b0;
        end
        else
        begin
            pd_reg      <= disabled;
            // Up alone drives low, down alone drives high, neither, both or disabled floats
            eo_oe_n_reg <= disabled || (up_req_raw == dw_req_raw);
            eo_out_reg  <= dw_req_raw && !up_req_raw;
        end
    end

    assign up_req = up_req_raw && !disabled;
    assign dw_req = dw_req_raw && !disabled;

    //////////////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            rdata_reg <= 16'h0000;
        else if (bus_req.rd)
        begin
            rdata_reg <= 16'h0000;
            if (bus_req.addr == prd_pkg::ADDR_REF_SEL)
                rdata_reg[3:0] <= ref_sel_reg;
            else if (bus_req.addr == prd_pkg::ADDR_PLL_CTRL)
                rdata_reg[prd_pkg::CTRL_EXT_BIT] <= ext_flag_reg;
            else if (bus_req.addr == prd_pkg::ADDR_PLL_DATA)
                rdata_reg <= div_value_reg;
            else if (bus_req.addr == prd_pkg::ADDR_STATUS)
            begin
                rdata_reg[prd_pkg::STAT_DIS_BIT] <= disabled;
                rdata_reg[prd_pkg::STAT_CE_BIT]  <= ce_filt_reg;
            end
        end
    end

    assign bus_rdata                    = rdata_reg;
    assign ref_tick                     = ref_tick_reg;
    assign synth_disable                = disabled;
    assign div_value                    = div_value_reg;
    assign swallow_count_ext            = div_ext_reg;
    assign local_osc_high_band_pulldown = pd_reg;
    assign local_osc_low_band_pulldown  = pd_reg;
    assign error_output_one             = '{out: eo_out_reg, oe_n: eo_oe_n_reg};
    assign error_output_zero            = '{out: eo_out_reg, oe_n: eo_oe_n_reg};

    //////////////////////////////////////////////////////////////////////////////////////
    // Checks; helper counts crystal edges between ticks at one stable setting
    logic [12:0] h_edges_reg;
    logic        h_valid_reg;
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || sel_wr || disabled)
        begin
            h_edges_reg <= 13'h0000;
            h_valid_reg <= 1'b0;
        end
        else if (ref_tick_reg)
        begin
            h_edges_reg <= 13'h0000;
            h_valid_reg <= 1'b1;
        end
        else if (xtal_tick)
            h_edges_reg <= h_edges_reg + 13'h0001;
    end
    ref_period_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ref_tick_reg && h_valid_reg && !sel_wr |-> h_edges_reg == divisor)
        else $error("reference period differs from divisor");

    no_tick_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        disabled ##1 disabled |-> !ref_tick_reg)
        else $error("reference tick while disabled");

    pull_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        sel_off |=> local_osc_high_band_pulldown && local_osc_low_band_pulldown)
        else $error("oscillator inputs not pulled low");

    err_float_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        sel_off |=> error_output_one.oe_n && error_output_zero.oe_n)
        else $error("error outputs driven while disabled");

    ext_capture_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        bus_req.wr && bus_req.addr == prd_pkg::ADDR_PLL_DATA
        |=> swallow_count_ext == $past(ext_flag_reg))
        else $error("extension flag not taken with data write");

    ext_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(bus_req.wr && bus_req.addr == prd_pkg::ADDR_PLL_DATA) |=> $stable(swallow_count_ext))
        else $error("extension output moved without data write");

    req_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        disabled |-> !up_req && !dw_req)
        else $error("comparator request while disabled");

    sel_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wdt_sp_rst || ce_rst || clock_stop |=> ref_sel_reg == prd_pkg::REF_SEL_OFF)
        else $error("selection not forced off by reset source");

    sel_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        bus_req.rd && bus_req.addr == prd_pkg::ADDR_REF_SEL
        |=> bus_rdata == {12'h000, $past(ref_sel_reg)})
        else $error("selection readback wrong");

endmodule

// file: inc/prd_pkg.sv
// Package: register map, divider counts and carrier types for the reference divider
package prd_pkg;

    // Register map (byte addresses on the plain port)
    localparam logic [7:0]  ADDR_REF_SEL   = 8'h11;
    localparam logic [7:0]  ADDR_PLL_CTRL  = 8'h13;
    localparam logic [7:0]  ADDR_PLL_DATA  = 8'h14;
    localparam logic [7:0]  ADDR_STATUS    = 8'h15;

    // Field positions
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          STAT_DIS_BIT   = 0;
    localparam int          STAT_CE_BIT    = 1;

    // Reset values
    localparam logic [3:0]  REF_SEL_RST    = 4'hf;
    localparam logic [3:0]  REF_SEL_OFF    = 4'hf;
    localparam logic [15:0] PLL_DATA_RST   = 16'h0000;

    // Crystal rate and reference rates in Hz
    localparam int          XTAL_HZ        = 4500000;
    localparam int          FR_1K          = 1000;
    localparam int          FR_1K25        = 1250;
    localparam int          FR_2K5         = 2500;
    localparam int          FR_3K          = 3000;
    localparam int          FR_5K          = 5000;
    localparam int          FR_6K25        = 6250;
    localparam int          FR_9K          = 9000;
    localparam int          FR_10K         = 10000;
    localparam int          FR_12K5        = 12500;
    localparam int          FR_18K         = 18000;
    localparam int          FR_20K         = 20000;
    localparam int          FR_25K         = 25000;
    localparam int          FR_50K         = 50000;

    // Crystal periods per reference period
    localparam logic [12:0] DIV_1K         = 13'(XTAL_HZ / FR_1K);
    localparam logic [12:0] DIV_1K25       = 13'(XTAL_HZ / FR_1K25);
    localparam logic [12:0] DIV_2K5        = 13'(XTAL_HZ / FR_2K5);
    localparam logic [12:0] DIV_3K         = 13'(XTAL_HZ / FR_3K);
    localparam logic [12:0] DIV_5K         = 13'(XTAL_HZ / FR_5K);
    localparam logic [12:0] DIV_6K25       = 13'(XTAL_HZ / FR_6K25);
    localparam logic [12:0] DIV_9K         = 13'(XTAL_HZ / FR_9K);
    localparam logic [12:0] DIV_10K        = 13'(XTAL_HZ / FR_10K);
    localparam logic [12:0] DIV_12K5       = 13'(XTAL_HZ / FR_12K5);
    localparam logic [12:0] DIV_18K        = 13'(XTAL_HZ / FR_18K);
    localparam logic [12:0] DIV_20K        = 13'(XTAL_HZ / FR_20K);
    localparam logic [12:0] DIV_25K        = 13'(XTAL_HZ / FR_25K);
    localparam logic [12:0] DIV_50K        = 13'(XTAL_HZ / FR_50K);
    localparam logic [12:0] DIV_NONE       = 13'h0000;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } prd_bus_req_t;

    // One error output pin: level and active-low enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } prd_pin_t;

endpackage

// file: verif/prd_comp_model.sv
// Far-side model: free-running crystal, comparator raw requests, tick period meter
`timescale 1ns/1ns
module prd_comp_model (
    // Clock and bench control
    input  wire logic        sys_clk,
    input  wire logic [1:0]  req_mode,
    // Block side
    input  wire logic        ref_tick,
    output logic             xtal_in,
    output logic             up_req_raw,
    output logic             dw_req_raw,
    // Crystal edges between the last two reference ticks
    output logic [15:0]      tick_period
);
    logic [15:0] edge_total = 16'h0000;
    logic [15:0] edge_mark  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Crystal never stops; 222 ns is the nearest whole-ns period to 4.5 MHz
    initial
    begin
        xtal_in = 1'b0;
        forever #111 xtal_in = ~xtal_in;
    end

    always @(posedge xtal_in) edge_total <= edge_total + 16'h0001;

    ////////////////////////////////////////////////////////////////////////////////
    // Tick lands long before the next crystal edge, so the count is exact
    always @(posedge sys_clk)
    begin
        if (ref_tick === 1'b1)
        begin
            tick_period <= edge_total - edge_mark;
            edge_mark   <= edge_total;
        end
    end

    // Comparator keeps requesting whether or not the synthesizer runs
    assign up_req_raw = (req_mode == 2'h1);
    assign dw_req_raw = (req_mode == 2'h2);
endmodule

// file: verif/prd_ref_div_tb.sv
// Self-checking bench for the reference divider
`timescale 1ns/1ns
module prd_ref_div_tb;
    logic                  sys_clk = 1'b0;
    logic                  nrst;
    prd_pkg::prd_bus_req_t bus_req;
    logic [15:0]           bus_rdata;
    logic                  wdt_sp_rst, ce_rst, clock_stop, ce_pin, xtal_in;
    logic                  up_req_raw, dw_req_raw, ref_tick, synth_disable;
    logic [15:0]           div_value;
    logic                  swallow_count_ext, up_req, dw_req, pd_hi, pd_lo;
    prd_pkg::prd_pin_t     eo_one, eo_zero;
    logic [1:0]            req_mode;
    logic [15:0]           tick_period;
    logic [15:0]           rd_val;
    int                    num_errors, n_compared, cycles;

    prd_ref_div DUT (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .wdt_sp_rst(wdt_sp_rst), .ce_rst(ce_rst), .clock_stop(clock_stop), .ce_pin(ce_pin),
        .xtal_in(xtal_in), .up_req_raw(up_req_raw), .dw_req_raw(dw_req_raw),
        .ref_tick(ref_tick), .synth_disable(synth_disable), .div_value(div_value),
        .swallow_count_ext(swallow_count_ext), .up_req(up_req), .dw_req(dw_req),
        .local_osc_high_band_pulldown(pd_hi), .local_osc_low_band_pulldown(pd_lo),
        .error_output_one(eo_one), .error_output_zero(eo_zero));

    prd_comp_model partner (.sys_clk(sys_clk), .req_mode(req_mode), .ref_tick(ref_tick),
        .xtal_in(xtal_in), .up_req_raw(up_req_raw), .dw_req_raw(dw_req_raw),
        .tick_period(tick_period));

    ////////////////////////////////////////////////////////////////////////////////
    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Bounded wait for one reference tick, then step past it
    task automatic wait_tick();
        int i;
        for (i = 0; i < 14000 && ref_tick !== 1'b1; i++) settle(1);
        check(ref_tick, 1'b1);
        settle(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus_rd(8'h11);
        check(rd_val, 16'h000f);
        check(synth_disable, 1'b1);
        check({pd_hi, pd_lo}, 2'h3);
        check({eo_one.oe_n, eo_zero.oe_n}, 2'h3);
        check(div_value, 16'h0000);
    endtask

    task automatic t_codes();
        for (int c = 0; c < 16; c++)
        begin
            bus_wr(8'h11, 16'(c));
            bus_rd(8'h11);
            check(rd_val, 16'(c));
            check(synth_disable, 1'(c == 15));
        end
    endtask

    task automatic t_rates();
        logic [3:0] codes [3] = '{4'h7, 4'h6, 4'ha};
        int         freqs [3] = '{50000, 25000, 18000};
        for (int k = 0; k < 3; k++)
        begin
            bus_wr(8'h11, 16'(codes[k]));
            wait_tick();
            wait_tick();
            check(tick_period, 16'(4500000 / freqs[k]));
        end
    endtask

    // Prohibited code: longer than the shortest reference period, no tick allowed
    task automatic t_no_rate();
        int ticks;
        ticks = 0;
        bus_wr(8'h11, 16'h000b);
        repeat (5200)
        begin
            settle(1);
            if (ref_tick !== 1'b0)
                ticks++;
        end
        check(16'(ticks), 16'h0000);
    endtask

    task automatic t_disable();
        @(posedge sys_clk) req_mode <= 2'h1;
        bus_wr(8'h11, 16'h0003);
        settle(4);
        check({up_req, dw_req, pd_hi, pd_lo}, 4'h8);
        check({eo_one, eo_zero}, 4'h0);
        @(posedge sys_clk) req_mode <= 2'h2;
        settle(4);
        check({up_req, dw_req, eo_one.out, eo_one.oe_n}, 4'h6);
        bus_wr(8'h11, 16'h000f);
        settle(4);
        check({up_req, dw_req}, 2'h0);
        check({eo_one.oe_n, eo_zero.oe_n}, 2'h3);
        check({pd_hi, pd_lo, synth_disable}, 3'h7);
        @(posedge sys_clk) req_mode <= 2'h0;
    endtask

    task automatic t_ext();
        bus_wr(8'h13, 16'h0001);
        settle(2);
        check(swallow_count_ext, 1'b0);
        bus_rd(8'h13);
        check(rd_val, 16'h0001);
        bus_wr(8'h14, 16'h1234);
        #1;
        check(div_value, 16'h1234);
        check(swallow_count_ext, 1'b1);
        bus_wr(8'h13, 16'h0000);
        settle(2);
        check(swallow_count_ext, 1'b1);
        bus_rd(8'h14);
        check(rd_val, 16'h1234);
        bus_rd(8'h13);
        check(rd_val, 16'h0000);
    endtask

    task automatic t_resets();
        for (int s = 0; s < 3; s++)
        begin
            bus_wr(8'h11, 16'h0003);
            @(posedge sys_clk);
            {wdt_sp_rst, ce_rst, clock_stop} <= 3'(3'h4 >> s);
            @(posedge sys_clk);
            {wdt_sp_rst, ce_rst, clock_stop} <= 3'h0;
            bus_rd(8'h11);
            check(rd_val, 16'h000f);
        end
    endtask

    task automatic t_ce();
        bus_wr(8'h11, 16'h0003);
        ce_pin <= 1'b0;
        settle(6);
        check(synth_disable, 1'b1);
        bus_rd(8'h11);
        check(rd_val, 16'h0003);
        bus_rd(8'h15);
        check(rd_val, 16'h0001);
        @(posedge sys_clk) ce_pin <= 1'b1;
        settle(6);
        check(synth_disable, 1'b0);
        bus_rd(8'h15);
        check(rd_val, 16'h0002);
        bus_rd(8'h20);
        check(rd_val, 16'h0000);
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        bus_req = '0;
        {wdt_sp_rst, ce_rst, clock_stop} = 3'h0;
        ce_pin = 1'b1;
        req_mode = 2'h0;
        num_errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_codes();
        t_rates();
        t_no_rate();
        t_disable();
        t_ext();
        t_resets();
        t_ce();
        complete_run();
    end
endmodule
